//--- design/analog_scan_trigger_pacer.v
// analog scan control: trigger, pacer, channel queue, sample fifo
// assumes one ahb-lite master, converter on hclk giving a done pulse
`timescale 1ns/100ps
`include "scan_pacer_map.vh"
module analog_scan_trigger_pacer (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire ext_trigger_in,
	input wire ext_sample_clk_in,
	output reg sample_clk_out,
	output reg conv_start,
	output reg [2:0] conv_channel,
	output reg [1:0] conv_range,
	output reg conv_differential_cfg,
	input wire conv_done,
	input wire [15:0] conv_data,
	output reg scan_active
);
	localparam FW = `SAMPLE_W + 3;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg wr_pend;
	reg rd_pend;
	reg [7:0] dp_addr;
	reg arm;
	reg clk_ext;
	reg differential_cfg;
	reg ext_trigger_in_level_mode;
	reg ext_trigger_in_pol_low;
	reg [31:0] period;
	reg [2:0] q_last;
	reg running;
	reg ext_trigger_in_gated;
	reg overrun;
	reg busy;
	reg [2:0] elem;
	reg [2:0] busy_elem;
	reg [32:0] acc;
	reg ck1;
	reg ck2;
	reg ck_last;
	reg [31:0] next_rdata;
	wire [4:0] q_ent [0:`QUEUE_DEPTH-1];
	wire addr_ok;
	wire wr_now;
	wire sw_start;
	wire sw_stop;
	wire ext_trigger_in_event;
	wire ext_trigger_in_asserted;
	wire ext_trigger_in_start;
	wire pace_gate;
	wire [32:0] acc_sum;
	wire int_tick;
	wire ext_edge;
	wire tick;
	wire take;
	wire refuse;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire fifo_pop;
	wire [FW-1:0] fifo_out;
	wire [`FIFO_AW:0] fifo_level;
	wire [4:0] cur_ent;

	// ----------------------------------------
	// ahb-lite slave: zero-wait writes, one wait state on reads
	// ----------------------------------------
	assign addr_ok = hsel & hready & htrans[1];
	assign wr_now = wr_pend;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			dp_addr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			if (rd_pend) begin
				rd_pend <= 1'b0;
				hreadyout <= 1'b1;
				hrdata <= next_rdata;
			end else if (addr_ok) begin
				dp_addr <= haddr[7:0];
				wr_pend <= hwrite;
				if (!hwrite) begin
					rd_pend <= 1'b1;
					hreadyout <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		next_rdata = 32'h0000_0000;
		case (dp_addr)
			`REG_CTRL: begin
				next_rdata[`CTRL_ARM] = arm;
				next_rdata[`CTRL_EXT_CLK] = clk_ext;
				next_rdata[`CTRL_DIFFERENTIAL_CFG] = differential_cfg;
				next_rdata[`CTRL_LEVEL] = ext_trigger_in_level_mode;
				next_rdata[`CTRL_POL_LOW] = ext_trigger_in_pol_low;
			end
			`REG_PERIOD: begin
				next_rdata = period;
			end
			`REG_QLAST: begin
				next_rdata[2:0] = q_last;
			end
			`REG_STATUS: begin
				next_rdata[`STAT_RUN] = running;
				next_rdata[`STAT_ARMED] = arm;
				next_rdata[`STAT_OVERRUN] = overrun;
				next_rdata[`STAT_BUSY] = busy;
				next_rdata[`STAT_LEVEL_HI:`STAT_LEVEL_LO] = fifo_level;
				next_rdata[`STAT_ELEM_HI:`STAT_ELEM_LO] = elem;
			end
			`REG_DATA: begin
				next_rdata[FW-1:0] = fifo_out;
				next_rdata[`DATA_VALID] = fifo_out_valid;
			end
			default: begin
				if (dp_addr[7:5] == 3'h1) begin
					next_rdata[4:0] = q_ent[dp_addr[4:2]];
				end
			end
		endcase
	end

	assign fifo_pop = rd_pend & (dp_addr == `REG_DATA) & fifo_out_valid;

	// ----------------------------------------
	// control register
	// ----------------------------------------
	assign sw_start = wr_now & (dp_addr == `REG_CTRL) & hwdata[`CTRL_START];
	assign sw_stop = wr_now & (dp_addr == `REG_CTRL) & hwdata[`CTRL_STOP];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_ext <= 1'b0;
			differential_cfg <= 1'b0;
			ext_trigger_in_level_mode <= 1'b0;
			ext_trigger_in_pol_low <= 1'b0;
			period <= `RST_PERIOD;
			q_last <= `RST_QLAST;
		end else if (wr_now) begin
			case (dp_addr)
				`REG_CTRL: begin
					clk_ext <= hwdata[`CTRL_EXT_CLK];
					differential_cfg <= hwdata[`CTRL_DIFFERENTIAL_CFG];
					ext_trigger_in_level_mode <= hwdata[`CTRL_LEVEL];
					ext_trigger_in_pol_low <= hwdata[`CTRL_POL_LOW];
				end
				`REG_PERIOD: begin
					period <= hwdata;
				end
				`REG_QLAST: begin
					q_last <= hwdata[2:0];
				end
				default: begin
					q_last <= q_last;
				end
			endcase
		end
	end

	// ----------------------------------------
	// channel and range queue
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `QUEUE_DEPTH; gi = gi + 1) begin : g_queue
			reg [4:0] ent;
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ent <= 5'h00;
				end else if (wr_now && dp_addr == (`REG_QUEUE + 4 * gi)) begin
					ent <= hwdata[4:0];
				end
			end
			assign q_ent[gi] = ent;
		end
	endgenerate

	assign cur_ent = q_ent[elem];

	// ----------------------------------------
	// trigger
	// ----------------------------------------
	trigger_qualifier u_ext_trigger_in (
		.clk(hclk),
		.rst_n(hresetn),
		.ext_trigger_in(ext_trigger_in),
		.level_mode(ext_trigger_in_level_mode),
		.polarity_low(ext_trigger_in_pol_low),
		.ext_trigger_in_event(ext_trigger_in_event),
		.ext_trigger_in_asserted(ext_trigger_in_asserted)
	);

	// edge starts once; level also gates pacing while deasserted if the trigger started the scan
	assign ext_trigger_in_start = arm & (ext_trigger_in_level_mode ? ext_trigger_in_asserted : ext_trigger_in_event);
	assign pace_gate = ~ext_trigger_in_gated | ~ext_trigger_in_level_mode | ext_trigger_in_asserted;

	// ----------------------------------------
	// pacer: internal timebase or external clock
	// ----------------------------------------
	assign acc_sum = acc + `TB_STEP;
	assign int_tick = running & (acc_sum >= {1'b0, period});

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc <= 33'h0_0000_0000;
		end else if (!running || clk_ext) begin
			acc <= 33'h0_0000_0000;
		end else if (int_tick) begin
			acc <= (acc_sum >= {1'b0, period, 1'b0}) ? 33'h0_0000_0000 : acc_sum - {1'b0, period};
		end else begin
			acc <= acc_sum;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck1 <= 1'b0;
			ck2 <= 1'b0;
			ck_last <= 1'b0;
		end else begin
			ck1 <= ext_sample_clk_in;
			ck2 <= ck1;
			ck_last <= ck2;
		end
	end

	assign ext_edge = ck2 & ~ck_last;
	assign tick = running & pace_gate & (clk_ext ? ext_edge : int_tick);
	assign take = tick & ~busy & fifo_in_ready;
	assign refuse = tick & ~take;

	// ----------------------------------------
	// scan sequencing
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			arm <= 1'b0;
			running <= 1'b0;
			ext_trigger_in_gated <= 1'b0;
			overrun <= 1'b0;
			busy <= 1'b0;
			elem <= 3'h0;
			busy_elem <= 3'h0;
		end else begin
			if (sw_stop) begin
				running <= 1'b0;
				arm <= 1'b0;
			end else if (!running && (sw_start || ext_trigger_in_start)) begin
				running <= 1'b1;
				arm <= 1'b0;
				ext_trigger_in_gated <= ~sw_start & ext_trigger_in_start;
				elem <= 3'h0;
			end else begin
				if (wr_now && dp_addr == `REG_CTRL && hwdata[`CTRL_ARM]) begin
					arm <= 1'b1;
				end
				if (take) begin
					elem <= (elem == q_last) ? 3'h0 : elem + 3'h1;
				end
			end
			if (take) begin
				busy <= 1'b1;
				busy_elem <= elem;
			end else if (conv_done) begin
				busy <= 1'b0;
			end
			// set wins over the write-one clear
			if (refuse) begin
				overrun <= 1'b1;
			end else if (wr_now && dp_addr == `REG_STATUS && hwdata[`STAT_OVERRUN]) begin
				overrun <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// converter and clock outputs
	// ----------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conv_start <= 1'b0;
			conv_channel <= 3'h0;
			conv_range <= `RANGE_10V;
			conv_differential_cfg <= 1'b0;
			sample_clk_out <= 1'b0;
			scan_active <= 1'b0;
		end else begin
			conv_start <= take;
			if (take) begin
				// differential numbering uses channels 0..3 only
				conv_channel <= differential_cfg ? {1'b0, cur_ent[1:0]} : cur_ent[`Q_CHAN_HI:0];
				conv_range <= cur_ent[`Q_RANGE_HI:`Q_RANGE_LO];
				conv_differential_cfg <= differential_cfg;
			end
			sample_clk_out <= ~clk_ext & int_tick;
			scan_active <= running;
		end
	end

	// ----------------------------------------
	// sample fifo
	// ----------------------------------------
	sample_fifo #(
		.WIDTH(FW),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(conv_done & busy),
		.in_ready(fifo_in_ready),
		.in_data({busy_elem, conv_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out),
		.level(fifo_level)
	);
endmodule

//--- design/sample_fifo.v
// sample fifo between the converter and the bus read port
// assumes depth is a power of two; single clock
`timescale 1ns/100ps
module sample_fifo #(
	parameter WIDTH = 19,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	output wire [AW:0] level
);
	localparam [AW:0] FULL = DEPTH[AW:0];
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp;
	reg [AW-1:0] rp;
	reg [AW:0] cnt;
	wire push;
	wire pop;

	assign in_ready = (cnt != FULL);
	assign out_valid = (cnt != {(AW+1){1'b0}});
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rp];
	assign level = cnt;

	always @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
			case ({push, pop})
				2'b10: cnt <= cnt + 1'b1;
				2'b01: cnt <= cnt - 1'b1;
				default: cnt <= cnt;
			endcase
		end
	end
endmodule

//--- design/scan_pacer_map.vh
// constants for the analog scan trigger and pacer block
// assumes an ahb-lite bus with 32-bit words and a 40 MHz hclk
//
// Functional notes
// - software picks edge or level qualification of the external trigger
// - edge mode fires on a rising or falling trigger transition, as configured
// - level mode treats trigger asserted while high, or while low
// - after reset the trigger is edge mode, rising edge
// - conversions paced by internal sample clock or external sample clock input
// - internal rate is the 80 MHz timebase divided by a 32-bit period
// - queue holds up to 8 elements, each with its own channel and range
// - each element picks one of four spans: 10, 5, 2 or 1 volt bipolar
// - software picks 4 differential or 8 single-ended channels; numbering follows
// - with internal clock selected the scan clock appears on the clock output
// - scan starts by software or qualified trigger, runs until stopped
`ifndef SCAN_PACER_MAP_VH
`define SCAN_PACER_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_PERIOD 8'h04
`define REG_QLAST 8'h08
`define REG_STATUS 8'h0c
`define REG_DATA 8'h10
`define REG_QUEUE 8'h20

// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_ARM 2
`define CTRL_EXT_CLK 3
`define CTRL_DIFFERENTIAL_CFG 4
`define CTRL_LEVEL 5
`define CTRL_POL_LOW 6

// ----------------------------------------
// status and data fields
// ----------------------------------------
`define STAT_RUN 0
`define STAT_ARMED 1
`define STAT_OVERRUN 2
`define STAT_BUSY 3
`define STAT_LEVEL_LO 4
`define STAT_LEVEL_HI 8
`define STAT_ELEM_LO 9
`define STAT_ELEM_HI 11
`define DATA_VALID 31

// ----------------------------------------
// queue element fields and ranges
// ----------------------------------------
`define Q_CHAN_HI 2
`define Q_RANGE_LO 3
`define Q_RANGE_HI 4
`define RANGE_10V 2'h0
`define RANGE_5V 2'h1
`define RANGE_2V 2'h2
`define RANGE_1V 2'h3

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define RST_PERIOD 32'h0000_0140
`define RST_QLAST 3'h0
`define QUEUE_DEPTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define SAMPLE_W 16

// ----------------------------------------
// timing
// ----------------------------------------
`define TIMEBASE_MHZ 80
`define HCLK_MHZ 40
`define TB_STEP (`TIMEBASE_MHZ / `HCLK_MHZ)

`endif

//--- design/trigger_qualifier.v
// external trigger synchroniser and qualifier
// assumes the trigger pin is asynchronous to clk
`timescale 1ns/100ps
module trigger_qualifier (
	input wire clk,
	input wire rst_n,
	input wire ext_trigger_in,
	input wire level_mode,
	input wire polarity_low,
	output reg ext_trigger_in_event,
	output wire ext_trigger_in_asserted
);
	reg sync1;
	reg sync2;
	reg last;
	wire rise;
	wire fall;

	assign rise = sync2 & ~last;
	assign fall = ~sync2 & last;
	// level condition, high or low per polarity
	assign ext_trigger_in_asserted = level_mode & (sync2 ^ polarity_low);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			last <= 1'b0;
			ext_trigger_in_event <= 1'b0;
		end else begin
			sync1 <= ext_trigger_in;
			sync2 <= sync1;
			last <= sync2;
			ext_trigger_in_event <= ~level_mode & (polarity_low ? fall : rise);
		end
	end
endmodule

//--- test/conv_model.sv
// converter stand-in: answers each start with a done pulse
// assumes one conversion in flight; delay alternates 2 and 4 cycles
`timescale 1ns/100ps
module conv_model (
	input wire clk,
	input wire rst_n,
	input wire conv_start,
	input wire [2:0] conv_channel,
	output reg conv_done,
	output reg [15:0] conv_data
);
	reg busy;
	reg slow;
	reg [1:0] cnt;
	reg [2:0] ch;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{busy, slow, cnt, ch, conv_done} <= 0;
			conv_data <= 16'h0;
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_start) begin
				busy <= 1'b1;
				cnt <= slow ? 2'h3 : 2'h1;
				ch <= conv_channel;
				slow <= !slow;
			end else if (busy) begin
				cnt <= cnt - 2'h1;
				if (cnt == 2'h0) begin
					busy <= 1'b0;
					conv_done <= 1'b1;
					conv_data <= {13'h0, ch};
				end
			end
		end
	end
endmodule

//--- test/scan_pacer_checker.sv
// port assertions for the scan pacer
// assumes hready is tied to hreadyout
`timescale 1ns/100ps
module scan_pacer_checker (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire sample_clk_out,
	input wire conv_start,
	input wire [2:0] conv_channel,
	input wire [1:0] conv_range,
	input wire conv_differential_cfg,
	input wire scan_active
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire taken = hsel && hready && htrans[1];
	init_idle_a: assert property ($rose(hresetn) |-> !scan_active && !conv_start && hreadyout)
		else $error("outputs busy after reset");
	clk_out_run_a: assert property (sample_clk_out |-> scan_active || $past(scan_active))
		else $error("clock pulse outside scan");
	start_in_scan_a: assert property (conv_start |-> scan_active || $past(scan_active))
		else $error("conversion outside scan");
	conv_single_a: assert property (conv_start |=> !conv_start)
		else $error("back to back conversion");
	differential_cfg_chan_a: assert property (conv_start && conv_differential_cfg |-> !conv_channel[2])
		else $error("differential channel above 3");
	elem_hold_a: assert property (conv_start |=> $stable(conv_channel) && $stable(conv_range))
		else $error("element fields moved");
	read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait wrong");
	write_now_a: assert property (taken && hwrite |=> hreadyout ##1 (hreadyout || $past(taken)))
		else $error("write stalled");
endmodule
bind analog_scan_trigger_pacer scan_pacer_checker chk_i (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .sample_clk_out, .conv_start, .conv_channel, .conv_range, .conv_differential_cfg, .scan_active);

//--- test/tb_top.sv
// bench for the scan pacer: bus tasks and scan scenarios
// assumes conv_model on the converter side
`timescale 1ns/100ps
module tb_top;
	// ------------------------------
	// stimulus and monitors
	// ------------------------------
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trg = 0, ext = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	wire hready, hresp, sclk, cst, cdiff, cdone, act;
	wire [2:0] cch;
	wire [1:0] crng;
	wire [15:0] cdata;
	int failures = 0, check_count = 0, cyc = 0, last = 0, gap = 0, pulses = 0, base, n;
	logic [5:0] seen[$];
	always #12.5 hclk = ~hclk;
	analog_scan_trigger_pacer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ext_trigger_in(trg),
		.ext_sample_clk_in(ext), .sample_clk_out(sclk), .conv_start(cst), .conv_channel(cch),
		.conv_range(crng), .conv_differential_cfg(cdiff), .conv_done(cdone), .conv_data(cdata), .scan_active(act));
	conv_model model (.clk(hclk), .rst_n(hresetn), .conv_start(cst), .conv_channel(cch),
		.conv_done(cdone), .conv_data(cdata));
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cst) seen.push_back({cdiff, crng, cch});
		if (sclk) begin
			gap <= cyc - last;
			last <= cyc;
			pulses <= pulses + 1;
		end
		if (cyc == 8000) begin
			failures++;
			give_verdict;
		end
	end
	task give_verdict;
		if (failures == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		@(posedge hclk);
		while (!hready) @(posedge hclk);
		r = hrdata;
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		bus(0, a, 0);
		chk(nm, e, r & m);
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1;
		rdc("ctrl", 8'h00, 32'h7c, 0);
		rdc("period", 8'h04, 32'hffffffff, 32'h140);
		rdc("qlast", 8'h08, 32'h7, 0);
		rdc("unmapped", 8'h80, 32'hffffffff, 0);
		chk("resp", 0, hresp);
		for (int i = 0; i < 8; i++) bus(1, 8'h20 + 4 * i, {27'h0, 2'(i), 3'(7 - i)});
		for (int i = 0; i < 8; i++) rdc("queue", 8'h20 + 4 * i, 32'h1f, {2'(i), 3'(7 - i)});
		bus(1, 8'h08, 2);
		bus(1, 8'h04, 16);
		bus(1, 8'h00, 1);
		while (seen.size() < 16) @(posedge hclk);
		repeat (40) @(posedge hclk);
		for (int k = 0; k < 6; k++) chk("elem", {3'(k % 3), 3'(7 - k % 3)}, seen[k]);
		chk("tick gap", 8, gap);
		rdc("status", 8'h0c, 32'h1f5, 32'h105);
		bus(1, 8'h00, 2);
		for (int k = 0; k < 16; k++)
			rdc("data", 8'h10, 32'h8007ffff, {1'b1, 12'h0, 3'(k % 3), 16'(7 - k % 3)});
		rdc("empty", 8'h10, 32'h80000000, 0);
		bus(1, 8'h0c, 32'h4);
		rdc("stopped", 8'h0c, 32'h5, 0);
		base = seen.size();
		bus(1, 8'h00, 32'h11);
		while (seen.size() == base) @(posedge hclk);
		bus(1, 8'h00, 2);
		chk("differential_cfg", 6'h23, seen[base]);
		repeat (10) @(posedge hclk);
		base = seen.size();
		n = pulses;
		bus(1, 8'h00, 32'h9);
		repeat (3) begin
			repeat (8) @(posedge hclk);
			ext <= 1;
			repeat (8) @(posedge hclk);
			ext <= 0;
		end
		repeat (10) @(posedge hclk);
		bus(1, 8'h00, 2);
		chk("ext starts", 3, seen.size() - base);
		chk("clk out", n, pulses);
		for (int m = 0; m < 4; m++) begin
			trg <= m[0];
			repeat (4) @(posedge hclk);
			bus(1, 8'h00, {25'h0, m[0], m[1], 5'h4});
			repeat (8) @(posedge hclk);
			chk("idle", 0, act);
			trg <= !m[0];
			for (n = 0; n < 20 && act !== 1'b1; n++) @(posedge hclk);
			chk("ext_trigger_in", 1, act);
			bus(1, 8'h00, 2);
		end
		give_verdict;
	end
endmodule
